//--- inc/csoc_cfg.svh
// Offsets, field positions, reset values and write masks of the codec status and output control registers.
`ifndef CSOC_CFG_SVH
`define CSOC_CFG_SVH

`define CSOC_ADDR_W           7
`define CSOC_OFF_FLAGS        7'h24
`define CSOC_OFF_PWR          7'h25
`define CSOC_OFF_HPDRV        7'h26
`define CSOC_OFF_RSVD         7'h27
`define CSOC_OFF_STAGE        7'h28

`define CSOC_RST_PWR          8'h00
`define CSOC_RST_HPDRV        8'h00
`define CSOC_RST_RSVD         8'h00
`define CSOC_RST_STAGE        8'h00
`define CSOC_RST_FLAGS        8'h00

`define CSOC_PWR_WMASK        8'hf0
`define CSOC_HPDRV_WMASK      8'h3e
`define CSOC_STAGE_WMASK      8'hff

`define CSOC_PWR_LDAC_BIT     7
`define CSOC_PWR_RDAC_BIT     6
`define CSOC_PWR_LCOM_HI      5
`define CSOC_PWR_LCOM_LO      4
`define CSOC_HP_RCOM_HI       5
`define CSOC_HP_RCOM_LO       3
`define CSOC_HP_SCP_EN_BIT    2
`define CSOC_HP_SCP_MODE_BIT  1
`define CSOC_ST_VCM_HI        7
`define CSOC_ST_VCM_LO        6
`define CSOC_ST_LBYP_HI       5
`define CSOC_ST_LBYP_LO       4
`define CSOC_ST_RBYP_HI       3
`define CSOC_ST_RBYP_LO       2
`define CSOC_ST_STEP_HI       1
`define CSOC_ST_STEP_LO       0

`endif

//--- inc/csoc_pkg.sv
// Types shared by the codec status and output control register bank.
package csoc_pkg;

    typedef enum logic [1:0] {
        CSOC_LCOM_DIFF,
        CSOC_LCOM_VCM,
        CSOC_LCOM_SE,
        CSOC_LCOM_RSVD
    } csoc_lcom_t;

    typedef enum logic [2:0] {
        CSOC_RCOM_DIFF_R,
        CSOC_RCOM_VCM,
        CSOC_RCOM_SE,
        CSOC_RCOM_DIFF_LCOM,
        CSOC_RCOM_EXT_FB,
        CSOC_RCOM_RSVD5,
        CSOC_RCOM_RSVD6,
        CSOC_RCOM_RSVD7
    } csoc_rcom_t;

    typedef enum logic [1:0] {
        CSOC_VCM_1V35,
        CSOC_VCM_1V50,
        CSOC_VCM_1V65,
        CSOC_VCM_1V80
    } csoc_vcm_t;

    typedef enum logic [1:0] {
        CSOC_BYP_OFF,
        CSOC_BYP_POS,
        CSOC_BYP_NEG,
        CSOC_BYP_DIFF
    } csoc_byp_t;

    typedef enum logic [1:0] {
        CSOC_STEP_1FS,
        CSOC_STEP_2FS,
        CSOC_STEP_OFF,
        CSOC_STEP_RSVD
    } csoc_step_t;

    // Live status of one ADC channel as seen by the analog and gain-control blocks.
    typedef struct packed {
        logic gain_settled;
        logic adc_powered;
        logic below_noise;
        logic agc_at_max;
    } csoc_chan_status_t;

    // Decoded analog control outputs.
    typedef struct packed {
        logic       left_dac_power;
        logic       right_dac_power;
        csoc_lcom_t left_common_terminal_driver;
        csoc_rcom_t right_common_terminal_driver;
        logic       short_protect_en;
        logic       short_protect_pwrdn;
        csoc_vcm_t  common_mode_level;
        csoc_byp_t  left_second_line_input;
        csoc_byp_t  right_second_line_input;
        csoc_step_t soft_step;
    } csoc_analog_ctrl_t;

endpackage : csoc_pkg

//--- design/csoc_regs.sv
// Codec ADC/AGC status and output driver control register bank.
`timescale 1ns/1ps
`include "csoc_cfg.svh"

// Behaviour
// - Flag bits 6 and 2 read 1 while the left or right ADC is powered up.
// - Flag bits 5 and 1 read 1 while left or right signal power is below the noise threshold.
// - Flag bits 4 and 0 read 1 while left or right automatic gain sits at its maximum.
// - Power register bits 7 and 6 power the left and right DAC, both off after reset.
// - Power register bits 5-4 choose the left common-terminal driver role.
// - Driver register bits 5-3 choose the right common-terminal driver role.
// - Driver register bit 2 enables short-circuit protection on all high-power drivers, off after reset.
// - Driver register bit 1 picks current limiting at 0 or automatic driver power-down at 1.
// - Stage register bits 7-6 select the output common-mode level.
// - Stage register bits 5-4 control the left second line input bypass.
// - Stage register bits 3-2 control the right second line input bypass.
// - Stage register bits 1-0 set output volume soft-stepping.
module csoc_regs
    import csoc_pkg::*;
#(
    parameter int ADDR_W = `CSOC_ADDR_W
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  csoc_chan_status_t      left_status_i,
    input  csoc_chan_status_t      right_status_i,
    output logic [7:0]             reg_rdata_o,
    output logic                   reg_rvalid_o,
    output csoc_analog_ctrl_t      analog_ctrl_o
);

    // ==========================================================================
    // Elaboration checks
    // ==========================================================================
    // Offset 0x28 needs six address bits; for wider buses the decoder zero-extends the offsets.
    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("csoc_regs: ADDR_W must reach offset 0x28");
    end
    if (`CSOC_PWR_LCOM_HI - `CSOC_PWR_LCOM_LO + 1 != $bits(csoc_lcom_t)) begin : g_bad_lcom_field
        $error("csoc_regs: left common-terminal field does not match its type");
    end
    if (`CSOC_HP_RCOM_HI - `CSOC_HP_RCOM_LO + 1 != $bits(csoc_rcom_t)) begin : g_bad_rcom_field
        $error("csoc_regs: right common-terminal field does not match its type");
    end
    if (`CSOC_ST_VCM_HI - `CSOC_ST_VCM_LO + 1 != $bits(csoc_vcm_t)) begin : g_bad_vcm_field
        $error("csoc_regs: common-mode field does not match its type");
    end
    if (`CSOC_ST_LBYP_HI - `CSOC_ST_LBYP_LO + 1 != $bits(csoc_byp_t)) begin : g_bad_lbyp_field
        $error("csoc_regs: left bypass field does not match its type");
    end
    if (`CSOC_ST_RBYP_HI - `CSOC_ST_RBYP_LO + 1 != $bits(csoc_byp_t)) begin : g_bad_rbyp_field
        $error("csoc_regs: right bypass field does not match its type");
    end
    if (`CSOC_ST_STEP_HI - `CSOC_ST_STEP_LO + 1 != $bits(csoc_step_t)) begin : g_bad_step_field
        $error("csoc_regs: soft-stepping field does not match its type");
    end

    // ==========================================================================
    // Address decode
    // ==========================================================================
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [6:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    // Read value of one offset; the reserved slot and unmapped offsets read zero.
    function automatic logic [7:0] read_word(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        flags,
        input logic [7:0]        pwr,
        input logic [7:0]        hpdrv,
        input logic [7:0]        stage
    );
        logic [7:0] w;
        w = 8'h00;
        if (hit(a, `CSOC_OFF_FLAGS)) begin
            w = flags;
        end else if (hit(a, `CSOC_OFF_PWR)) begin
            w = pwr;
        end else if (hit(a, `CSOC_OFF_HPDRV)) begin
            w = hpdrv;
        end else if (hit(a, `CSOC_OFF_RSVD)) begin
            w = `CSOC_RST_RSVD;
        end else if (hit(a, `CSOC_OFF_STAGE)) begin
            w = stage;
        end
        read_word = w;
    endfunction : read_word

    // ==========================================================================
    // Storage
    // ==========================================================================
    localparam logic [7:0] RST_PWR   = `CSOC_RST_PWR;
    localparam logic [7:0] RST_HPDRV = `CSOC_RST_HPDRV;
    localparam logic [7:0] RST_STAGE = `CSOC_RST_STAGE;

    logic       wr_pwr;
    logic       wr_hpdrv;
    logic       wr_stage;
    logic       left_dac_q;
    logic       right_dac_q;
    csoc_lcom_t lcom_q;
    csoc_rcom_t rcom_q;
    logic       scp_en_q;
    logic       scp_mode_q;
    csoc_vcm_t  vcm_q;
    csoc_byp_t  lbyp_q;
    csoc_byp_t  rbyp_q;
    csoc_step_t step_q;
    logic [7:0] pwr_rd;
    logic [7:0] hpdrv_rd;
    logic [7:0] stage_rd;
    logic [7:0] flags_d;
    logic [7:0] flags_q;
    logic [7:0] rdata_d;

    // ==========================================================================
    // Write strobes
    // ==========================================================================
    // The flag register and the reserved slot have no strobe, so writes to them are dropped.
    always_comb begin
        wr_pwr   = reg_wr_i && hit(reg_addr_i, `CSOC_OFF_PWR);
        wr_hpdrv = reg_wr_i && hit(reg_addr_i, `CSOC_OFF_HPDRV);
        wr_stage = reg_wr_i && hit(reg_addr_i, `CSOC_OFF_STAGE);
    end

    // ==========================================================================
    // Power and left common-terminal fields
    // ==========================================================================
    // Reserved bits 3-0 are not stored, so they always read zero.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            left_dac_q <= RST_PWR[`CSOC_PWR_LDAC_BIT];
        end else if (wr_pwr) begin
            left_dac_q <= reg_wdata_i[`CSOC_PWR_LDAC_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            right_dac_q <= RST_PWR[`CSOC_PWR_RDAC_BIT];
        end else if (wr_pwr) begin
            right_dac_q <= reg_wdata_i[`CSOC_PWR_RDAC_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lcom_q <= csoc_lcom_t'(RST_PWR[`CSOC_PWR_LCOM_HI:`CSOC_PWR_LCOM_LO]);
        end else if (wr_pwr) begin
            lcom_q <= csoc_lcom_t'(reg_wdata_i[`CSOC_PWR_LCOM_HI:`CSOC_PWR_LCOM_LO]);
        end
    end

    // ==========================================================================
    // High-power driver fields
    // ==========================================================================
    // Reserved bits 7-6 and 0 are not stored, so they always read zero.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rcom_q <= csoc_rcom_t'(RST_HPDRV[`CSOC_HP_RCOM_HI:`CSOC_HP_RCOM_LO]);
        end else if (wr_hpdrv) begin
            rcom_q <= csoc_rcom_t'(reg_wdata_i[`CSOC_HP_RCOM_HI:`CSOC_HP_RCOM_LO]);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            scp_en_q <= RST_HPDRV[`CSOC_HP_SCP_EN_BIT];
        end else if (wr_hpdrv) begin
            scp_en_q <= reg_wdata_i[`CSOC_HP_SCP_EN_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            scp_mode_q <= RST_HPDRV[`CSOC_HP_SCP_MODE_BIT];
        end else if (wr_hpdrv) begin
            scp_mode_q <= reg_wdata_i[`CSOC_HP_SCP_MODE_BIT];
        end
    end

    // ==========================================================================
    // Output stage fields
    // ==========================================================================
    // All eight bits are stored; a reserved soft-stepping code is kept as written.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            vcm_q <= csoc_vcm_t'(RST_STAGE[`CSOC_ST_VCM_HI:`CSOC_ST_VCM_LO]);
        end else if (wr_stage) begin
            vcm_q <= csoc_vcm_t'(reg_wdata_i[`CSOC_ST_VCM_HI:`CSOC_ST_VCM_LO]);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lbyp_q <= csoc_byp_t'(RST_STAGE[`CSOC_ST_LBYP_HI:`CSOC_ST_LBYP_LO]);
        end else if (wr_stage) begin
            lbyp_q <= csoc_byp_t'(reg_wdata_i[`CSOC_ST_LBYP_HI:`CSOC_ST_LBYP_LO]);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rbyp_q <= csoc_byp_t'(RST_STAGE[`CSOC_ST_RBYP_HI:`CSOC_ST_RBYP_LO]);
        end else if (wr_stage) begin
            rbyp_q <= csoc_byp_t'(reg_wdata_i[`CSOC_ST_RBYP_HI:`CSOC_ST_RBYP_LO]);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            step_q <= csoc_step_t'(RST_STAGE[`CSOC_ST_STEP_HI:`CSOC_ST_STEP_LO]);
        end else if (wr_stage) begin
            step_q <= csoc_step_t'(reg_wdata_i[`CSOC_ST_STEP_HI:`CSOC_ST_STEP_LO]);
        end
    end

    // ==========================================================================
    // Read-back bytes
    // ==========================================================================
    // Stored fields are put back at their bit positions; unstored bits read zero.
    always_comb begin
        pwr_rd                                          = 8'h00;
        pwr_rd[`CSOC_PWR_LDAC_BIT]                      = left_dac_q;
        pwr_rd[`CSOC_PWR_RDAC_BIT]                      = right_dac_q;
        pwr_rd[`CSOC_PWR_LCOM_HI:`CSOC_PWR_LCOM_LO]     = lcom_q;
        hpdrv_rd                                        = 8'h00;
        hpdrv_rd[`CSOC_HP_RCOM_HI:`CSOC_HP_RCOM_LO]     = rcom_q;
        hpdrv_rd[`CSOC_HP_SCP_EN_BIT]                   = scp_en_q;
        hpdrv_rd[`CSOC_HP_SCP_MODE_BIT]                 = scp_mode_q;
        stage_rd                                        = 8'h00;
        stage_rd[`CSOC_ST_VCM_HI:`CSOC_ST_VCM_LO]       = vcm_q;
        stage_rd[`CSOC_ST_LBYP_HI:`CSOC_ST_LBYP_LO]     = lbyp_q;
        stage_rd[`CSOC_ST_RBYP_HI:`CSOC_ST_RBYP_LO]     = rbyp_q;
        stage_rd[`CSOC_ST_STEP_HI:`CSOC_ST_STEP_LO]     = step_q;
    end

    // ==========================================================================
    // Live status flags
    // ==========================================================================
    // Sampled every cycle from the hardware; reads never alter them.
    always_comb begin
        flags_d = {left_status_i.gain_settled,
                   left_status_i.adc_powered,
                   left_status_i.below_noise,
                   left_status_i.agc_at_max,
                   right_status_i.gain_settled,
                   right_status_i.adc_powered,
                   right_status_i.below_noise,
                   right_status_i.agc_at_max};
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags_q <= `CSOC_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ==========================================================================
    // Read port
    // ==========================================================================
    // Read data appears one cycle after the strobe and falls back to zero a cycle later.
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            rdata_d = read_word(reg_addr_i, flags_q, pwr_rd, hpdrv_rd, stage_rd);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_d;
        end
    end

    // ==========================================================================
    // Analog control outputs
    // ==========================================================================
    // Taken from the stored fields, so the outputs follow a write by two cycles.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            analog_ctrl_o <= '0;
        end else begin
            analog_ctrl_o.left_dac_power               <= left_dac_q;
            analog_ctrl_o.right_dac_power              <= right_dac_q;
            analog_ctrl_o.left_common_terminal_driver  <= lcom_q;
            analog_ctrl_o.right_common_terminal_driver <= rcom_q;
            analog_ctrl_o.short_protect_en             <= scp_en_q;
            // Power-down mode only matters while protection is on.
            analog_ctrl_o.short_protect_pwrdn          <= scp_en_q & scp_mode_q;
            analog_ctrl_o.common_mode_level            <= vcm_q;
            analog_ctrl_o.left_second_line_input       <= lbyp_q;
            analog_ctrl_o.right_second_line_input      <= rbyp_q;
            analog_ctrl_o.soft_step                    <= step_q;
        end
    end

endmodule : csoc_regs

//--- verification/csoc_regs_checker.sv
// Assertion checker for the codec status and output control register bank.
`timescale 1ns/1ps
module csoc_regs_checker
    import csoc_pkg::*;
#(
    parameter int ADDR_W = 7
) (
    input wire logic              clock_i,
    input wire logic              rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [7:0]        reg_wdata_i,
    input wire csoc_chan_status_t left_status_i,
    input wire csoc_chan_status_t right_status_i,
    input wire logic [7:0]        reg_rdata_o,
    input wire logic              reg_rvalid_o,
    input wire csoc_analog_ctrl_t analog_ctrl_o
);
    // =======
    // Checks.
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_rd_valid: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read valid");
    a_rd_idle: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00) else $error("idle rdata");
    a_flag_read: assert property (reg_rd_i && reg_addr_i == 'h24 && $past(rst_n_i) |=>
        reg_rdata_o == {$past(left_status_i, 2), $past(right_status_i, 2)}) else $error("flag read");
    a_pwr_ctrl: assert property (reg_wr_i && reg_addr_i == 'h25 |=> ##1 {analog_ctrl_o.left_dac_power,
        analog_ctrl_o.right_dac_power, analog_ctrl_o.left_common_terminal_driver} == $past(reg_wdata_i[7:4], 2))
        else $error("power ctrl");
    a_hp_ctrl: assert property (reg_wr_i && reg_addr_i == 'h26 |=> ##1 {analog_ctrl_o.right_common_terminal_driver,
        analog_ctrl_o.short_protect_en, analog_ctrl_o.short_protect_pwrdn}
        == {$past(reg_wdata_i[5:2], 2), &$past(reg_wdata_i[2:1], 2)}) else $error("driver ctrl");
    a_stage_ctrl: assert property (reg_wr_i && reg_addr_i == 'h28 |=> ##1 {analog_ctrl_o.common_mode_level,
        analog_ctrl_o.left_second_line_input, analog_ctrl_o.right_second_line_input, analog_ctrl_o.soft_step}
        == $past(reg_wdata_i, 2)) else $error("stage ctrl");
    a_ctrl_hold: assert property ($past(rst_n_i) && !$past(reg_wr_i, 2) |-> $stable(analog_ctrl_o))
        else $error("ctrl moved");
    a_rsvd_read: assert property (reg_rd_i && reg_addr_i == 'h27 |=> reg_rdata_o == 8'h00) else $error("rsvd read");
endmodule : csoc_regs_checker

bind csoc_regs csoc_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .left_status_i(left_status_i), .right_status_i(right_status_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .analog_ctrl_o(analog_ctrl_o));

//--- verification/csoc_host_model.sv
// Host processor model that reaches the register bank over its strobe port.
`timescale 1ns/1ps
module csoc_host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic [6:0]      addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      wdata_o
);
    initial begin
        addr_o = 7'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Reserved bits always go out as zero and the reserved slot is never written.
    // Released lines show inverted values; read data is taken at the edge after the strobe is released.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= (a == 7'h25) ? (d & 8'hf0) : (a == 7'h26) ? (d & 8'h3e) : d;
        wr_o <= (a != 7'h27);
        @(posedge clock_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clock_i);
        d = rdata_i;
        v = rvalid_i;
    endtask : rd
endmodule : csoc_host_model

//--- verification/tb.sv
// Self-checking testbench for the codec status and output control register bank.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import csoc_pkg::*;
    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic [6:0]        addr;
    logic              wr;
    logic              rd;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [7:0]        d;
    logic [7:0]        w;
    logic              rvalid;
    logic              v;
    csoc_chan_status_t ls = '0;
    csoc_chan_status_t rs = '0;
    csoc_analog_ctrl_t ctrl;
    csoc_analog_ctrl_t c0;
    int                errors = 0;
    int                checked = 0;
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    csoc_regs DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .left_status_i(ls), .right_status_i(rs), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .analog_ctrl_o(ctrl));
    csoc_host_model u_host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    // ==========
    // Sequences.
    task end_sim;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task rd_chk(input logic [6:0] a, input logic [7:0] e);
        u_host.rd(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask : rd_chk
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd_chk(7'h25, 8'h00);
        rd_chk(7'h26, 8'h00);
        rd_chk(7'h28, 8'h00);
        `CHK("ctrl", 17'h0, ctrl)
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            w = {2'(k + 1), 2'(k), 4'h0};
            u_host.wr(7'h25, w);
            rd_chk(7'h25, w);
            `CHK("dac", 2'(k + 1), {ctrl.left_dac_power, ctrl.right_dac_power})
            `CHK("lcom", 2'(k), ctrl.left_common_terminal_driver)
        end
        for (int j = 0; j < 5; j++) begin
            w = {2'b00, 3'(j), 2'(j), 1'b0};
            u_host.wr(7'h26, w);
            rd_chk(7'h26, w);
            `CHK("rcom", 3'(j), ctrl.right_common_terminal_driver)
            `CHK("scp", {j[1], j[1] & j[0]}, {ctrl.short_protect_en, ctrl.short_protect_pwrdn})
        end
        for (int i = 0; i < 4; i++) begin
            w = {2'(i), 2'(i), 2'(i), 2'(i % 3)};
            u_host.wr(7'h28, w);
            rd_chk(7'h28, w);
            `CHK("stage", w, {ctrl.common_mode_level, ctrl.left_second_line_input, ctrl.right_second_line_input, ctrl.soft_step})
        end
        $display("test control done");
        for (int i = 0; i < 3; i++) begin
            w = 8'h5a << i;
            @(posedge clock_i);
            ls <= w[7:4];
            rs <= w[3:0];
            rd_chk(7'h24, w);
            rd_chk(7'h24, w);
        end
        $display("test flags done");
        c0 = ctrl;
        // The model drops the reserved-slot write; the flag and unmapped writes must be ignored.
        u_host.wr(7'h24, 8'h00);
        u_host.wr(7'h27, 8'hff);
        u_host.wr(7'h7f, 8'hff);
        rd_chk(7'h27, 8'h00);
        rd_chk(7'h7f, 8'h00);
        rd_chk(7'h24, w);
        `CHK("ctrl_kept", c0, ctrl)
        $display("test refused done");
        end_sim();
    end
endmodule : tb
